// ### common/pap_pkg.sv
// package for the pci address/data phase port: constants and carrier structs
// assumes a single bus clock domain; no software-reached registers
package pap_pkg;
    localparam int ADDR_W = 32;
    localparam int BE_W = 4;
    localparam int SWAP_BIT_POS = 2; // position of byte_swap_enable in third_control_status_register
    localparam logic [1:0] BURST_LINEAR = 2'h0; // low address bits during master address phase
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam int DEVSEL_DELAY = 1; // claim in the clock after the address phase
    localparam logic [2:0] DEVSEL_WAIT_MAX = 3'h4; // unclaimed data clocks before the master gives up
    localparam int BUS_HZ_MAX = 33000000; // static design, any rate from zero up
    // bus side pin group, three signals per two-way pin
    typedef struct packed {
        logic [31:0] ad_o;
        logic ad_oe;
        logic [3:0] cbe_n_o;
        logic cbe_oe;
        logic frame_n_o;
        logic frame_oe;
        logic irdy_n_o;
        logic irdy_oe;
        logic trdy_n_o;
        logic trdy_oe;
        logic devsel_n_o;
        logic devsel_oe;
    } pap_pins_out_s;
    typedef struct packed {
        logic [31:0] ad_i;
        logic [3:0] cbe_n_i;
        logic frame_n_i;
        logic irdy_n_i;
        logic trdy_n_i;
        logic devsel_n_i;
    } pap_pins_in_s;
    // master request from the dma side
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [3:0] be_n;
        logic [7:0] count; // number of data phases, minus one
        logic fifo; // data belongs to a fifo transfer, swap may apply
    } pap_mreq_s;
endpackage

// ### logic/pap_port.sv
// pci address/data phase port: master framing, target claim, lane swap
// assumes every input is synchronous to clk_sys (the bus clock); other agents obey the bus protocol
module pap_port #(
    parameter logic [31:0] IO_BASE = 32'h0000_1000, // target window base, arbitrary default
    parameter int IO_SIZE_LOG2 = 5 // window size in address bits
) (
    input wire logic clk_sys, // bus clock
    input wire logic reset, // synchronous, active high
    input wire logic clk_en, // freezes all state but the nand tree register while low
    input wire logic rst_bus_n, // bus reset pin, selects nand tree test
    input wire logic [31:0] third_control_status_register, // software control word
    input wire pap_pkg::pap_pins_in_s pins_i, // sampled bus pins
    output pap_pkg::pap_pins_out_s pins_o, // driven bus pins and enables
    output logic nand_out, // nand tree result
    input wire logic grant, // bus granted to this master
    input wire logic mreq_valid, // master request pending
    input wire pap_pkg::pap_mreq_s mreq, // master request
    output logic mreq_ready, // request accepted
    input wire logic [31:0] mwr_data, // master write word, little-endian
    output logic mdata_take, // one data phase completed
    output logic [31:0] mrd_data_q, // master read word
    output logic mabort_q, // no agent claimed the access
    output logic [31:0] tgt_addr_q, // latched target address
    output logic [3:0] tgt_be_n_q, // latched target byte enables
    output logic [31:0] tgt_wdata_q, // target write word
    output logic tgt_wr_q, // target write strobe
    input wire logic [31:0] tgt_rdata // target read word
);
    typedef enum logic [2:0] {
        PAP_IDLE, PAP_MADDR, PAP_MDATA, PAP_TCLAIM, PAP_TDATA, PAP_TURN
    } pap_state_e;

    pap_state_e state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [31:0] addr_q, addr_d;
    logic [3:0] cmd_q, cmd_d;
    logic [3:0] be_q, be_d;
    logic fifo_q, fifo_d;
    logic [31:0] mrd_d, taddr_d, twd_d;
    logic [3:0] tbe_d;
    logic abort_d, twr_d;
    logic tread_q, tread_d;
    logic nand_d, nand_q;
    logic [2:0] nodev_q, nodev_d;

    // byte swap for fifo words only; byte enables never pass through here
    function automatic logic [31:0] lane_order(input logic [31:0] w, input logic swap);
        lane_order = swap ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    function automatic logic hit(input logic [31:0] a);
        hit = (a[31:IO_SIZE_LOG2] == IO_BASE[31:IO_SIZE_LOG2]);
    endfunction

    logic swap_on;
    logic phase_done;
    logic last_phase;
    assign swap_on = third_control_status_register[pap_pkg::SWAP_BIT_POS] & fifo_q;
    assign phase_done = ~pins_i.irdy_n_i & ~pins_i.trdy_n_i;
    assign last_phase = (cnt_q == 8'h00);

    // next state; all sampling relies on the rising edge only
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        cmd_d = cmd_q;
        be_d = be_q;
        fifo_d = fifo_q;
        mrd_d = mrd_data_q;
        abort_d = mabort_q;
        taddr_d = tgt_addr_q;
        tbe_d = tgt_be_n_q;
        twd_d = tgt_wdata_q;
        twr_d = 1'b0;
        tread_d = tread_q;
        nodev_d = nodev_q;
        mreq_ready = 1'b0;
        mdata_take = 1'b0;
        unique case (state_q)
            PAP_IDLE: begin
                if (mreq_valid && grant && pins_i.frame_n_i && pins_i.irdy_n_i) begin
                    mreq_ready = clk_en; // a frozen port takes nothing
                    addr_d = {mreq.addr[31:2], pap_pkg::BURST_LINEAR};
                    cmd_d = mreq.cmd;
                    be_d = mreq.be_n;
                    cnt_d = mreq.count;
                    fifo_d = mreq.fifo;
                    abort_d = 1'b0;
                    nodev_d = 3'h0;
                    state_d = PAP_MADDR;
                end else if (!pins_i.frame_n_i && hit(pins_i.ad_i) && (pins_i.cbe_n_i[3:1] == 3'h1)) begin
                    // address snooped while not master, io commands only
                    taddr_d = pins_i.ad_i;
                    tread_d = ~pins_i.cbe_n_i[0];
                    fifo_d = 1'b0;
                    state_d = PAP_TCLAIM;
                end
            end
            PAP_MADDR: begin
                state_d = PAP_MDATA;
            end
            PAP_MDATA: begin
                if (phase_done) begin
                    mdata_take = clk_en;
                    mrd_d = lane_order(pins_i.ad_i, swap_on); // latch on every completed master phase, read or write
                    cnt_d = cnt_q - 8'h01;
                    if (last_phase) state_d = PAP_TURN;
                end else if (pins_i.devsel_n_i) begin
                    // no agent has claimed yet; give up once the claim window is over
                    if (nodev_q == pap_pkg::DEVSEL_WAIT_MAX) begin
                        abort_d = 1'b1; // nobody claimed it
                        state_d = PAP_TURN;
                    end else begin
                        nodev_d = nodev_q + 3'h1;
                    end
                end
            end
            PAP_TCLAIM: begin
                state_d = PAP_TDATA;
            end
            PAP_TDATA: begin
                if (!pins_i.irdy_n_i) begin
                    tbe_d = pins_i.cbe_n_i;
                    if (!tread_q) begin
                        twd_d = pins_i.ad_i; // latch on target write
                        twr_d = 1'b1;
                    end
                    if (pins_i.frame_n_i) state_d = PAP_TURN;
                end
            end
            PAP_TURN: begin
                state_d = PAP_IDLE;
            end
            default: state_d = PAP_IDLE;
        endcase
    end

    // state registers; clk_en low freezes everything, the bus reset pin clears like reset
    always_ff @(posedge clk_sys) begin
        if (reset || !rst_bus_n) begin
            state_q <= PAP_IDLE;
            cnt_q <= 8'h00;
            addr_q <= pap_pkg::RST_WORD;
            cmd_q <= 4'h0;
            be_q <= 4'hf;
            fifo_q <= 1'b0;
            mrd_data_q <= pap_pkg::RST_WORD;
            mabort_q <= 1'b0;
            tgt_addr_q <= pap_pkg::RST_WORD;
            tgt_be_n_q <= 4'hf;
            tgt_wdata_q <= pap_pkg::RST_WORD;
            tgt_wr_q <= 1'b0;
            tread_q <= 1'b0;
            nodev_q <= 3'h0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            cmd_q <= cmd_d;
            be_q <= be_d;
            fifo_q <= fifo_d;
            mrd_data_q <= mrd_d;
            mabort_q <= abort_d;
            tgt_addr_q <= taddr_d;
            tgt_be_n_q <= tbe_d;
            tgt_wdata_q <= twd_d;
            tgt_wr_q <= twr_d;
            tread_q <= tread_d;
            nodev_q <= nodev_d;
        end
    end

    // nand tree over bus inputs while the bus reset pin is low
    always_comb begin
        nand_d = ~(&{pins_i.ad_i, pins_i.cbe_n_i, pins_i.frame_n_i, pins_i.devsel_n_i, clk_en});
    end
    always_ff @(posedge clk_sys) begin
        if (reset) nand_q <= 1'b0;
        else nand_q <= rst_bus_n ? 1'b0 : nand_d;
    end
    assign nand_out = nand_q;

    // pin drive; enables low in reset so every bus pin is an input
    logic mst, tgt_rd;
    assign mst = rst_bus_n && (state_q == PAP_MADDR || state_q == PAP_MDATA);
    assign tgt_rd = rst_bus_n && tread_q && (state_q == PAP_TDATA);
    always_comb begin
        pins_o = '0;
        pins_o.ad_oe = mst ? (state_q == PAP_MADDR || cmd_q[0]) : tgt_rd;
        pins_o.ad_o = (state_q == PAP_MADDR) ? addr_q :
            (tgt_rd ? tgt_rdata : lane_order(mwr_data, swap_on));
        pins_o.cbe_oe = mst;
        pins_o.cbe_n_o = (state_q == PAP_MADDR) ? cmd_q : be_q;
        pins_o.frame_oe = mst;
        pins_o.frame_n_o = !(state_q == PAP_MADDR || (state_q == PAP_MDATA && !last_phase));
        pins_o.irdy_oe = mst;
        pins_o.irdy_n_o = (state_q != PAP_MDATA);
        pins_o.trdy_oe = rst_bus_n && (state_q == PAP_TDATA);
        pins_o.trdy_n_o = (state_q != PAP_TDATA);
        pins_o.devsel_oe = rst_bus_n && (state_q == PAP_TCLAIM || state_q == PAP_TDATA);
        pins_o.devsel_n_o = 1'b0; // claim
    end

    // assertions; the target claim is built from its decode step and its claim step
    sequence s_io_match;
        state_q == PAP_IDLE && !pins_i.frame_n_i && hit(pins_i.ad_i) && pins_i.cbe_n_i[3:1] == 3'h1;
    endsequence
    sequence s_claimed;
        pins_o.devsel_oe && !pins_o.devsel_n_o;
    endsequence
    a_addr_low_zero: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == PAP_MADDR && pins_o.ad_oe) |-> pins_o.ad_o[1:0] == 2'h0)
        else $error("master address low bits not zero");
    a_frame_first: assert property (@(posedge clk_sys) disable iff (reset || !rst_bus_n)
        (state_q == PAP_MADDR) |-> (!pins_o.frame_n_o && pins_o.frame_oe))
        else $error("frame not asserted in address phase");
    a_float_idle: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == PAP_IDLE) |-> (!pins_o.ad_oe && !pins_o.cbe_oe))
        else $error("lanes driven while idle");
    a_reset_inputs: assert property (@(posedge clk_sys) disable iff (reset)
        !rst_bus_n |-> !(pins_o.ad_oe | pins_o.cbe_oe | pins_o.frame_oe | pins_o.devsel_oe))
        else $error("pin driven during bus reset");
    a_claim_after: assert property (@(posedge clk_sys) disable iff (reset || !rst_bus_n || !clk_en)
        s_io_match |=> s_claimed)
        else $error("no claim after match");
    a_claim_next: assert property (@(posedge clk_sys) disable iff (reset || !rst_bus_n || !clk_en)
        (state_q == PAP_TCLAIM) |=> (state_q == PAP_TDATA && pins_o.devsel_oe))
        else $error("claim not held into data phase");
    a_take_both: assert property (@(posedge clk_sys) disable iff (reset)
        mdata_take |-> (!pins_i.irdy_n_i && !pins_i.trdy_n_i))
        else $error("data phase taken without both readies");
    a_rd_swap: assert property (@(posedge clk_sys) disable iff (reset || !rst_bus_n || !clk_en)
        mdata_take |=> mrd_data_q == lane_order($past(pins_i.ad_i), $past(swap_on)))
        else $error("read word byte order wrong");
    a_frame_last: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == PAP_MDATA && last_phase) |-> pins_o.frame_n_o)
        else $error("frame still asserted in final phase");
    a_abort_no_claim: assert property (@(posedge clk_sys) disable iff (reset || !rst_bus_n || !clk_en)
        (state_q == PAP_MDATA && pins_i.devsel_n_i && !phase_done && nodev_q == pap_pkg::DEVSEL_WAIT_MAX)
        |=> (mabort_q && state_q == PAP_TURN))
        else $error("master abort not raised");
endmodule

// ### testbench/pap_far_target.sv
// far-side bus target answering the port's master cycles
// assumes one bus clock; controls have pull-ups, so an idle drive is modelled by oe low
module pap_far_target (
    input wire logic clk_sys, // bus clock
    input wire logic reset, // synchronous, active high
    input wire logic mute, // ignore every access, to provoke a master abort
    input wire pap_pkg::pap_pins_out_s dut, // port drive
    input wire logic [1:0] wait_n, // wait states per phase
    input wire logic [31:0] rdata, // bus word returned on reads
    output pap_pkg::pap_pins_out_s far // agent drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act_q;
    logic rd_q;
    logic [1:0] wt_q;
    // claim at the address phase; command bit 0 low marks a read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            act_q <= 1'b0;
            wt_q <= 2'h0;
        end else if (!act_q && !mute && dut.frame_oe && !dut.frame_n_o) begin
            act_q <= 1'b1;
            rd_q <= !dut.cbe_n_o[0];
            wt_q <= wait_n;
        end else if (act_q && !dut.irdy_n_o) begin
            if (wt_q != 2'h0) begin
                wt_q <= wt_q - 2'h1;
            end else begin
                wt_q <= wait_n;
                act_q <= !dut.frame_n_o; // frame high marks the last phase
            end
        end
    end
    // read data is driven for the whole claim, the port must have let go
    always_comb begin
        far = '0;
        far.devsel_oe = act_q;
        far.trdy_oe = act_q;
        far.trdy_n_o = wt_q != 2'h0;
        far.ad_oe = act_q && rd_q;
        far.ad_o = rdata;
    end
endmodule

// ### testbench/pci_address_data_phase_port_bench.sv
// self-checking bench for the address/data phase port
// assumes the far target model; the bench itself plays the master for target accesses
module pci_address_data_phase_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] cmd;
        logic fifo;
        logic swap;
        logic [3:0] be_n;
        logic [31:0] data;
    } pap_row_s;
    localparam logic [31:0] TBASE = 32'h0000_1000;
    logic clk_sys = 1'b0, reset = 1'b1, rst_bus_n = 1'b1, grant = 1'b1, mreq_valid = 1'b0;
    logic mreq_ready, mdata_take, mabort_q, tgt_wr_q, nand_out;
    logic [31:0] csr = 32'h0, mrd_data_q, tgt_addr_q, tgt_wdata_q, ad_q = 32'h0;
    logic [31:0] rdata = 32'h0, mwr_data = 32'h0, tgt_rdata = 32'h9abc_def0;
    logic [3:0] tgt_be_n_q, cb_q = 4'h0;
    logic [1:0] wait_n = 2'h0;
    logic mute = 1'b0;
    int fails = 0, checks = 0;
    pap_pkg::pap_mreq_s mreq = '0;
    pap_pkg::pap_pins_out_s po, fa, tb = '0;
    pap_pkg::pap_pins_in_s pi;
    pap_row_s rows [6] = '{'{pap_pkg::CMD_MEM_WRITE, 1'b1, 1'b0, 4'h0, 32'h1122_3344},
        '{pap_pkg::CMD_MEM_WRITE, 1'b1, 1'b1, 4'ha, 32'h5566_7788}, '{pap_pkg::CMD_MEM_WRITE, 1'b0, 1'b1, 4'h3, 32'ha1b2_c3d4},
        '{pap_pkg::CMD_MEM_READ, 1'b1, 1'b1, 4'h0, 32'h0102_0304}, '{pap_pkg::CMD_IO_READ, 1'b0, 1'b0, 4'he, 32'hcafe_0042},
        '{pap_pkg::CMD_IO_WRITE, 1'b0, 1'b0, 4'h7, 32'h0bad_f00d}};
    // clock at 250 mhz
    always #2 clk_sys = ~clk_sys;
    // wire levels: controls pulled up, released lanes show the inverse of their last level
    always_comb begin
        pi.ad_i = po.ad_oe ? po.ad_o : fa.ad_oe ? fa.ad_o : tb.ad_oe ? tb.ad_o : ~ad_q;
        pi.cbe_n_i = po.cbe_oe ? po.cbe_n_o : tb.cbe_oe ? tb.cbe_n_o : ~cb_q;
        pi.frame_n_i = po.frame_oe ? po.frame_n_o : !tb.frame_oe || tb.frame_n_o;
        pi.irdy_n_i = po.irdy_oe ? po.irdy_n_o : !tb.irdy_oe || tb.irdy_n_o;
        pi.trdy_n_i = po.trdy_oe ? po.trdy_n_o : !fa.trdy_oe || fa.trdy_n_o;
        pi.devsel_n_i = po.devsel_oe ? po.devsel_n_o : !fa.devsel_oe || fa.devsel_n_o;
    end
    // last lane levels, for the released-lane pattern
    always @(posedge clk_sys) begin
        ad_q <= pi.ad_i;
        cb_q <= pi.cbe_n_i;
    end
    pap_port #(.IO_BASE(TBASE), .IO_SIZE_LOG2(5)) u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
        .rst_bus_n(rst_bus_n), .third_control_status_register(csr), .pins_i(pi), .pins_o(po), .nand_out(nand_out),
        .grant(grant), .mreq_valid(mreq_valid), .mreq(mreq), .mreq_ready(mreq_ready), .mwr_data(mwr_data),
        .mdata_take(mdata_take), .mrd_data_q(mrd_data_q), .mabort_q(mabort_q), .tgt_addr_q(tgt_addr_q),
        .tgt_be_n_q(tgt_be_n_q), .tgt_wdata_q(tgt_wdata_q), .tgt_wr_q(tgt_wr_q), .tgt_rdata(tgt_rdata));
    pap_far_target u_far (.clk_sys(clk_sys), .reset(reset), .mute(mute), .dut(po), .wait_n(wait_n), .rdata(rdata),
        .far(fa));
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error %0t %s", $time, m);
        end
    endtask
    task automatic close_out();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one master transfer of n+1 phases against the far target
    task automatic mxfer(input logic [31:0] a, input pap_row_s r, input logic [7:0] n, input logic [1:0] w);
        logic [31:0] d;
        int k;
        int p;
        d = (r.fifo && r.swap) ? {r.data[7:0], r.data[15:8], r.data[23:16], r.data[31:24]} : r.data;
        @(posedge clk_sys);
        csr <= {29'h0, r.swap, 2'h0};
        wait_n <= w;
        rdata <= r.data;
        mwr_data <= r.data;
        mreq <= '{addr: a, cmd: r.cmd, be_n: r.be_n, count: n, fifo: r.fifo};
        mreq_valid <= 1'b1;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (mreq_ready !== 1'b1 && k < 20);
        @(posedge clk_sys);
        mreq_valid <= 1'b0;
        @(negedge clk_sys);
        chk(po.frame_oe && !po.frame_n_o && po.cbe_oe, "no address phase");
        chk(po.ad_oe && po.ad_o === {a[31:2], pap_pkg::BURST_LINEAR}, "address lanes");
        chk(po.cbe_n_o === r.cmd, "command lanes");
        p = 0;
        for (k = 0; k < 60 && p <= int'(n); k++) begin
            @(negedge clk_sys);
            if (mdata_take === 1'b1) begin
                chk(po.cbe_n_o === r.be_n, "byte enables");
                chk(po.frame_n_o === (p == int'(n)), "frame at phase");
                chk(po.ad_oe === r.cmd[0] && (!r.cmd[0] || po.ad_o === d), "data lanes");
                p++;
            end
        end
        chk(p == int'(n) + 1, "phase count");
        @(negedge clk_sys);
        chk(r.cmd[0] || mrd_data_q === d, "read word");
        chk(!po.ad_oe && !po.cbe_oe && !po.frame_oe, "lanes not released");
        chk(mabort_q === 1'b0, "false master abort");
    endtask
    // one single-phase target access driven by the bench as master
    task automatic tacc(input logic [3:0] cmd, input logic [31:0] a, input logic claim);
        int k;
        @(posedge clk_sys);
        tb <= '{ad_o: a, ad_oe: 1'b1, cbe_n_o: cmd, cbe_oe: 1'b1, frame_n_o: 1'b0, frame_oe: 1'b1, irdy_oe: 1'b1,
            irdy_n_o: 1'b1, default: '0};
        @(posedge clk_sys);
        tb <= '{ad_o: 32'h5a5a_c3c3, ad_oe: cmd[0], cbe_n_o: 4'h6, cbe_oe: 1'b1, frame_n_o: 1'b1, frame_oe: 1'b1,
            irdy_oe: 1'b1, irdy_n_o: 1'b0, default: '0};
        @(negedge clk_sys);
        chk((po.devsel_oe && !po.devsel_n_o) === claim, "claim");
        for (k = 0; k < 10 && claim && !(po.trdy_oe && !po.trdy_n_o); k++) begin
            @(negedge clk_sys);
        end
        chk(!claim || cmd[0] || (po.ad_oe && po.ad_o === tgt_rdata), "target read word");
        @(posedge clk_sys);
        tb <= '0;
        @(negedge clk_sys);
        chk(tgt_wr_q === (claim && cmd[0]), "target write strobe");
        @(negedge clk_sys);
        chk(!claim || (tgt_addr_q === a && tgt_be_n_q === 4'h6), "target address");
        chk(!claim || !cmd[0] || tgt_wdata_q === 32'h5a5a_c3c3, "target write word");
        chk(!po.ad_oe && !po.cbe_oe, "target lanes held");
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #100000;
        fails++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            mxfer(32'h4000_0103 + 32'(i) * 32'h10, rows[i], 8'h0, 2'(i % 3));
        end
        mxfer(32'h4000_0800, rows[1], 8'h2, 2'h2); // burst with stalls
        mxfer(32'h4000_0900, rows[3], 8'h1, 2'h0);
        tacc(pap_pkg::CMD_IO_WRITE, TBASE + 32'h8, 1'b1);
        tacc(pap_pkg::CMD_IO_READ, TBASE + 32'h1c, 1'b1);
        tacc(pap_pkg::CMD_MEM_READ, TBASE + 32'h8, 1'b0);
        tacc(pap_pkg::CMD_IO_READ, TBASE + 32'h40, 1'b0);
        // nobody claims: the port has to give up on its own
        @(posedge clk_sys);
        mute <= 1'b1;
        mreq <= '{addr: 32'h4000_0c00, cmd: pap_pkg::CMD_MEM_READ, be_n: 4'h0, count: 8'h0, fifo: 1'b0};
        mreq_valid <= 1'b1;
        @(posedge clk_sys);
        mreq_valid <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(mabort_q === 1'b1 && !po.frame_oe, "no master abort");
        @(posedge clk_sys);
        mute <= 1'b0;
        grant <= 1'b0;
        mreq_valid <= 1'b1;
        repeat (5) @(negedge clk_sys);
        chk(!po.frame_oe, "start without grant");
        @(posedge clk_sys);
        mreq_valid <= 1'b0;
        grant <= 1'b1;
        rst_bus_n <= 1'b0;
        tb <= '{ad_o: 32'hffff_ffff, ad_oe: 1'b1, cbe_n_o: 4'hf, cbe_oe: 1'b1, default: '0};
        repeat (3) @(negedge clk_sys);
        chk(!(po.ad_oe | po.cbe_oe | po.frame_oe | po.devsel_oe | po.irdy_oe | po.trdy_oe), "test mode drive");
        chk(nand_out === 1'b0, "nand tree all high");
        @(posedge clk_sys);
        tb.ad_o <= 32'hffff_fffe;
        repeat (2) @(negedge clk_sys);
        chk(nand_out === 1'b1, "nand tree lane low");
        @(posedge clk_sys);
        rst_bus_n <= 1'b1;
        tb <= '0;
        mxfer(32'h4000_0a00, rows[0], 8'h0, 2'h1);
        close_out();
    end
endmodule
